// [inc/dac_link_pkg.sv]
// Shared constants for the two-wire converter link and its controller.
package dac_link_pkg;

    // ****************************************************************
    // Link framing
    // ****************************************************************
    localparam logic [6:0] SLAVE_ADDR_BASE = 7'h4c;
    localparam int         ADDR_SEL_POS    = 1;
    localparam logic [3:0] BITS_PER_BYTE   = 4'h8;
    localparam logic [1:0] LAST_BYTE       = 2'h3;
    localparam logic [1:0] READ_LAST_BYTE  = 2'h2;
    localparam logic [1:0] FIRST_DATA_BYTE = 2'h2;

    // ****************************************************************
    // Control byte fields and power-down mode bits of the data word
    // ****************************************************************
    localparam int CTRL_UPD_HI = 5;
    localparam int CTRL_UPD_LO = 4;
    localparam int CTRL_BCAST  = 2;
    localparam int CTRL_SRC    = 1;
    localparam int CTRL_PD     = 0;
    localparam int PD_MODE_HI  = 15;
    localparam int PD_MODE_LO  = 13;

    // ****************************************************************
    // Timing
    // ****************************************************************
    localparam int         CLK_PERIOD_NS  = 5;
    localparam int         SCL_PHASE_NS   = 625;
    localparam int         SCL_PHASE_CYC  = (SCL_PHASE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam logic [7:0] SCL_PHASE_LAST = 8'(SCL_PHASE_CYC - 1);

    // ****************************************************************
    // Controller registers
    // ****************************************************************
    localparam logic [11:0] CMD_OFS    = 12'h000;
    localparam logic [11:0] CTRL_OFS   = 12'h004;
    localparam logic [11:0] DATA_OFS   = 12'h008;
    localparam logic [11:0] STATUS_OFS = 12'h00c;
    localparam int          CMD_GO     = 0;
    localparam int          CMD_READ   = 1;
    localparam int          CMD_SEL    = 2;
    localparam int          CMD_HOLD   = 3;
    localparam int          CMD_PAIR   = 4;
    localparam int          ST_BUSY    = 0;
    localparam int          ST_NACK    = 1;
    localparam int          ST_RXC_LO  = 8;
    localparam logic [7:0]  CTRL_RST   = 8'h00;
    localparam logic [15:0] DATA_RST   = 16'h0000;

endpackage

// [inc/dac_link_if.sv]
// Open-drain two-wire link joining the controller and the converter end.
`timescale 1ns/1ps
interface dac_link_if;
    logic m_scl_out;
    logic m_scl_oe;
    logic m_sda_out;
    logic m_sda_oe;
    logic s_sda_out;
    logic s_sda_oe;
    logic scl;
    logic sda;

    assign scl = !(m_scl_oe && !m_scl_out);
    assign sda = !((m_sda_oe && !m_sda_out) || (s_sda_oe && !s_sda_out));

    modport host (output m_scl_out, m_scl_oe, m_sda_out, m_sda_oe, input scl, sda);
    modport device (output s_sda_out, s_sda_oe, input scl, sda);
endinterface

// [src/dac_link_device.sv]
// Converter end of the two-wire link: slave receiver and transmitter.
//
// Overview of operation
// - Master opens transfers with a start condition.
// - Data changes only while clock is low.
// - Answer address 1001100, select pin sets bit1.
// - Pull data low in ninth clock on match.
// - Write: address, then control byte layout.
// - High data byte follows, device acknowledges it.
// - Low data byte follows, device acknowledges it.
// - Power-down flag: mode byte, zero byte, acknowledged.
// - Byte pairs repeat without address or control.
// - Master uses repeated start for further writes.
// - Read: address byte with direction bit one.
// - After read ack, send high byte MSB first.
// - Master acknowledges each wanted returned byte.
// - On master ack, send low byte next.
// - Then send control byte as third byte.
// - Master leaves line high after control byte.
// - Master then stops or repeats start.
// - Stop: data rises while clock high.
// - Returned data from converter or holding register.
// - Convert at falling edge after low ack.
// - Stop keeps state, waits for new address.
// - Converter code is plain unsigned binary.
//
// The register addresses and the APB slave port were left to the implementer.
`timescale 1ns/1ps
module dac_link_device
    import dac_link_pkg::*;
(
    input  wire logic        pclk,
    input  wire logic        presetn,
    dac_link_if.device       link,
    input  wire logic        address_select_pin,
    output wire logic [15:0] dac_code,
    output wire logic        conv_start,
    output wire logic [1:0]  update_mode,
    output wire logic        broadcast_sel,
    output wire logic        powerdown_flag_bit,
    output wire logic        powerdown_mode_bit_a,
    output wire logic        powerdown_mode_bit_b,
    output wire logic        powerdown_mode_bit_c
);

    // ****************************************************************
    // State
    // ****************************************************************
    typedef enum logic [2:0] {
        S_IDLE,
        S_RX,
        S_RX_ACK,
        S_ACK_DRV,
        S_TX,
        S_TX_ACK
    } dev_state_t;

    typedef struct packed {
        logic        scl_s1;
        logic        scl_s2;
        logic        scl_p;
        logic        sda_s1;
        logic        sda_s2;
        logic        sda_p;
        logic        sel_s1;
        logic        sel_s2;
        dev_state_t  state;
        logic [3:0]  bit_cnt;
        logic [7:0]  shift;
        logic [1:0]  byte_idx;
        logic        ack_now;
        logic        rd_mode;
        logic        hold_tmp;
        logic        sda_oe;
        logic        conv_pulse;
        logic [7:0]  ctrl;
        logic [15:0] hold;
        logic [15:0] dac;
        logic [2:0]  pd_mode;
    } dev_regs_t;

    localparam dev_regs_t DEV_RST = '0;

    dev_regs_t  r;
    dev_regs_t  n;
    logic       rise;
    logic       fall;
    logic       start_cond;
    logic       stop_cond;
    logic [7:0] rx_byte;

    // ****************************************************************
    // Helpers
    // ****************************************************************
    function automatic logic addr_match(input logic [7:0] b, input logic sel);
        logic [6:0] own;
        own               = SLAVE_ADDR_BASE;
        own[ADDR_SEL_POS] = sel;
        return b[7:1] == own;
    endfunction

    function automatic logic [7:0] tx_pick(input logic [1:0] idx, input dev_regs_t s);
        logic [15:0] src;
        logic [7:0]  c;
        src         = s.hold_tmp ? s.hold : s.dac;
        c           = s.ctrl;
        c[CTRL_SRC] = s.hold_tmp;
        unique case (idx)
            2'h0:    return src[15:8];
            2'h1:    return src[7:0];
            default: return c;
        endcase
    endfunction

    assign rise       = r.scl_s2 && !r.scl_p;
    assign fall       = !r.scl_s2 && r.scl_p;
    assign start_cond = r.scl_s2 && r.scl_p && r.sda_p && !r.sda_s2;
    assign stop_cond  = r.scl_s2 && r.scl_p && !r.sda_p && r.sda_s2;
    assign rx_byte    = {r.shift[6:0], r.sda_s2};

    // ****************************************************************
    // Next state
    // ****************************************************************
    always_comb begin
        n            = r;
        n.scl_s1     = link.scl;
        n.scl_s2     = r.scl_s1;
        n.scl_p      = r.scl_s2;
        n.sda_s1     = link.sda;
        n.sda_s2     = r.sda_s1;
        n.sda_p      = r.sda_s2;
        n.sel_s1     = address_select_pin;
        n.sel_s2     = r.sel_s1;
        n.conv_pulse = 1'b0;
        if (start_cond) begin
            n.state    = S_RX;
            n.bit_cnt  = 4'h0;
            n.byte_idx = 2'h0;
            n.sda_oe   = 1'b0;
        end else if (stop_cond) begin
            n.state  = S_IDLE;
            n.sda_oe = 1'b0;
        end else begin
            unique case (r.state)
                S_IDLE: begin
                    n.sda_oe = 1'b0;
                end
                S_RX: begin
                    if (rise) begin
                        n.shift   = rx_byte;
                        n.bit_cnt = r.bit_cnt + 4'h1;
                        if (r.bit_cnt == BITS_PER_BYTE - 4'h1) begin
                            n.state = S_RX_ACK;
                            unique case (r.byte_idx)
                                2'h0: begin
                                    n.rd_mode = rx_byte[0];
                                    if (!addr_match(rx_byte, r.sel_s2)) begin
                                        n.state = S_IDLE;
                                    end
                                end
                                2'h1: begin
                                    n.ctrl = rx_byte;
                                end
                                2'h2: begin
                                    n.hold[15:8] = rx_byte;
                                    n.hold_tmp   = 1'b1;
                                end
                                default: begin
                                    n.hold[7:0] = rx_byte;
                                end
                            endcase
                        end
                    end
                end
                S_RX_ACK: begin
                    if (fall) begin
                        n.sda_oe = 1'b1;
                        n.state  = S_ACK_DRV;
                    end
                end
                S_ACK_DRV: begin
                    if (fall) begin
                        n.sda_oe  = 1'b0;
                        n.bit_cnt = 4'h0;
                        if (r.byte_idx == 2'h0 && r.rd_mode) begin
                            n.state    = S_TX;
                            n.byte_idx = 2'h0;
                            n.shift    = tx_pick(2'h0, r);
                            n.sda_oe   = !n.shift[7];
                        end else begin
                            n.state = S_RX;
                            if (r.byte_idx == LAST_BYTE) begin
                                n.byte_idx   = FIRST_DATA_BYTE;
                                n.conv_pulse = 1'b1;
                                n.hold_tmp   = 1'b0;
                                if (r.ctrl[CTRL_PD]) begin
                                    n.pd_mode = r.hold[PD_MODE_HI:PD_MODE_LO];
                                end else begin
                                    n.dac = r.hold;
                                end
                            end else begin
                                n.byte_idx = r.byte_idx + 2'h1;
                            end
                        end
                    end
                end
                S_TX: begin
                    if (rise) begin
                        n.bit_cnt = r.bit_cnt + 4'h1;
                    end else if (fall) begin
                        if (r.bit_cnt == BITS_PER_BYTE) begin
                            n.sda_oe = 1'b0;
                            n.state  = S_TX_ACK;
                        end else begin
                            n.shift  = {r.shift[6:0], 1'b0};
                            n.sda_oe = !r.shift[6];
                        end
                    end
                end
                S_TX_ACK: begin
                    if (rise) begin
                        n.ack_now = !r.sda_s2;
                    end else if (fall) begin
                        if (r.ack_now) begin
                            n.byte_idx = (r.byte_idx == READ_LAST_BYTE) ? 2'h0 : r.byte_idx + 2'h1;
                            n.shift    = tx_pick(n.byte_idx, r);
                            n.sda_oe   = !n.shift[7];
                            n.bit_cnt  = 4'h0;
                            n.state    = S_TX;
                        end else begin
                            n.state = S_IDLE;
                        end
                    end
                end
            endcase
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            r <= DEV_RST;
        end else begin
            r <= n;
        end
    end

    // ****************************************************************
    // Outputs
    // ****************************************************************
    assign link.s_sda_out       = 1'b0;
    assign link.s_sda_oe        = r.sda_oe;
    assign dac_code             = r.dac;
    assign conv_start           = r.conv_pulse;
    assign update_mode          = r.ctrl[CTRL_UPD_HI:CTRL_UPD_LO];
    assign broadcast_sel        = r.ctrl[CTRL_BCAST];
    assign powerdown_flag_bit   = r.ctrl[CTRL_PD];
    assign powerdown_mode_bit_a = r.pd_mode[2];
    assign powerdown_mode_bit_b = r.pd_mode[1];
    assign powerdown_mode_bit_c = r.pd_mode[0];

endmodule // dac_link_device

// [src/dac_link_host.sv]
// Controller end of the two-wire link, steered over APB registers.
`timescale 1ns/1ps
module dac_link_host
    import dac_link_pkg::*;
(
    input  wire logic        pclk,
    input  wire logic        presetn,
    dac_link_if.host         link,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output wire logic [31:0] prdata,
    output wire logic        pready,
    output wire logic        pslverr
);

    // ****************************************************************
    // State
    // ****************************************************************
    typedef enum logic [3:0] {
        M_IDLE, M_START, M_LO_A, M_LO_B, M_HI,
        M_STOP_A, M_STOP_B, M_STOP_C, M_STOP_D, M_HOLD, M_RESTART
    } host_state_t;

    typedef struct packed {
        logic        sda_s1;
        logic        sda_s2;
        host_state_t state;
        logic [7:0]  tick;
        logic [3:0]  bit_cnt;
        logic [1:0]  byte_idx;
        logic [7:0]  shift;
        logic        read_op;
        logic        addr_sel;
        logic        hold_bus;
        logic        nack;
        logic        scl_oe;
        logic        sda_oe;
        logic [7:0]  ctrl_byte;
        logic [15:0] data;
        logic [7:0]  rx_ctrl;
        logic [31:0] prdata;
    } host_regs_t;

    localparam host_regs_t HOST_RST = '0;

    host_regs_t r;
    host_regs_t n;
    logic       busy;
    logic       tx_mode;
    logic       phase_end;
    logic       wr_en;
    logic       mapped;

    function automatic logic [7:0] tx_pick(input logic [1:0] idx, input host_regs_t s);
        logic [6:0] a;
        a               = SLAVE_ADDR_BASE;
        a[ADDR_SEL_POS] = s.addr_sel;
        unique case (idx)
            2'h0:    return {a, s.read_op};
            2'h1:    return s.ctrl_byte;
            2'h2:    return s.data[15:8];
            default: return s.data[7:0];
        endcase
    endfunction

    assign busy      = r.state != M_IDLE && r.state != M_HOLD;
    assign tx_mode   = !r.read_op || r.byte_idx == 2'h0;
    assign phase_end = r.tick == SCL_PHASE_LAST;
    assign wr_en     = psel && penable && pwrite && !busy;
    assign mapped    = paddr == CMD_OFS || paddr == CTRL_OFS || paddr == DATA_OFS || paddr == STATUS_OFS;

    // ****************************************************************
    // Next state
    // ****************************************************************
    always_comb begin
        n        = r;
        n.sda_s1 = link.sda;
        n.sda_s2 = r.sda_s1;
        n.tick   = (busy && !phase_end) ? r.tick + 8'h1 : 8'h0;
        if (psel && !penable) begin
            unique case (paddr)
                CMD_OFS:    n.prdata = {28'h0, r.hold_bus, r.addr_sel, r.read_op, busy};
                CTRL_OFS:   n.prdata = {24'h0, r.ctrl_byte};
                DATA_OFS:   n.prdata = {16'h0, r.data};
                STATUS_OFS: n.prdata = {16'h0, r.rx_ctrl, 6'h0, r.nack, busy};
                default:    n.prdata = 32'h0;
            endcase
        end
        if (wr_en && paddr == CTRL_OFS) begin
            n.ctrl_byte = pwdata[7:0];
        end
        if (wr_en && paddr == DATA_OFS) begin
            n.data = pwdata[15:0];
        end
        if (wr_en && paddr == CMD_OFS) begin
            n.read_op  = pwdata[CMD_READ];
            n.addr_sel = pwdata[CMD_SEL];
            n.hold_bus = pwdata[CMD_HOLD];
            if (pwdata[CMD_GO]) begin
                n.nack  = 1'b0;
                n.state = (r.state == M_HOLD) ? M_RESTART : M_START;
                if (r.state == M_IDLE) begin
                    n.sda_oe = 1'b1;
                end
                if (r.state == M_HOLD && pwdata[CMD_PAIR]) begin
                    n.state    = M_LO_A;
                    n.byte_idx = FIRST_DATA_BYTE;
                    n.shift    = tx_pick(FIRST_DATA_BYTE, r);
                end
            end
        end
        if (phase_end) begin
            unique case (r.state)
                M_RESTART: begin
                    n.scl_oe = 1'b0;
                    n.state  = M_START;
                end
                M_START: begin
                    if (r.scl_oe) begin
                        n.state = M_RESTART;
                    end else if (!r.sda_oe) begin
                        n.sda_oe = 1'b1;
                    end else begin
                        n.scl_oe   = 1'b1;
                        n.bit_cnt  = 4'h0;
                        n.byte_idx = 2'h0;
                        n.shift    = tx_pick(2'h0, r);
                        n.state    = M_LO_A;
                    end
                end
                M_LO_A: begin
                    n.state = M_LO_B;
                    if (r.bit_cnt != BITS_PER_BYTE) begin
                        n.sda_oe = tx_mode && !r.shift[7];
                    end else begin
                        n.sda_oe = !tx_mode && r.byte_idx != LAST_BYTE;
                    end
                end
                M_LO_B: begin
                    n.scl_oe = 1'b0;
                    n.state  = M_HI;
                end
                M_HI: begin
                    n.scl_oe = 1'b1;
                    n.state  = M_LO_A;
                    if (r.bit_cnt != BITS_PER_BYTE) begin
                        n.shift   = {r.shift[6:0], r.sda_s2};
                        n.bit_cnt = r.bit_cnt + 4'h1;
                    end else begin
                        n.sda_oe  = 1'b0;
                        n.bit_cnt = 4'h0;
                        if (!tx_mode) begin
                            unique case (r.byte_idx)
                                2'h1:    n.data[15:8] = r.shift;
                                2'h2:    n.data[7:0]  = r.shift;
                                default: n.rx_ctrl    = r.shift;
                            endcase
                        end
                        if (tx_mode && r.sda_s2) begin
                            n.nack  = 1'b1;
                            n.state = M_STOP_A;
                        end else if (r.byte_idx == LAST_BYTE) begin
                            n.state = r.hold_bus ? M_HOLD : M_STOP_A;
                        end else begin
                            n.byte_idx = r.byte_idx + 2'h1;
                            n.shift    = tx_pick(n.byte_idx, r);
                        end
                    end
                end
                M_STOP_A: begin
                    n.sda_oe = 1'b1;
                    n.state  = M_STOP_B;
                end
                M_STOP_B: begin
                    n.scl_oe = 1'b0;
                    n.state  = M_STOP_C;
                end
                M_STOP_C: begin
                    n.sda_oe = 1'b0;
                    n.state  = M_STOP_D;
                end
                M_STOP_D: begin
                    n.state = M_IDLE;
                end
                default: begin
                end
            endcase
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            r <= HOST_RST;
        end else begin
            r <= n;
        end
    end

    assign link.m_scl_out = 1'b0;
    assign link.m_scl_oe  = r.scl_oe;
    assign link.m_sda_out = 1'b0;
    assign link.m_sda_oe  = r.sda_oe;
    assign prdata         = r.prdata;
    assign pready         = 1'b1;
    assign pslverr        = psel && penable && !mapped;

endmodule // dac_link_host

// [bench/dac_link_asserts.sv]
// Checker watching the signals of the two-wire link.
`timescale 1ns/1ps
module dac_link_asserts (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic m_sda_oe,
    input wire logic s_sda_oe,
    input wire logic scl,
    input wire logic sda
);
    // ********
    // Framing tracker
    // ********
    logic       scl_q;
    logic       sda_q;
    logic [3:0] bit_cnt;
    logic       first_byte;
    wire logic  start_ev = scl && scl_q && sda_q && !sda;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            scl_q <= 1'b1;
            sda_q <= 1'b1;
            bit_cnt <= 4'h0;
            first_byte <= 1'b0;
        end else begin
            scl_q <= scl;
            sda_q <= sda;
            if (start_ev) begin
                bit_cnt <= 4'h0;
                first_byte <= 1'b1;
            end else if (scl && !scl_q) begin
                bit_cnt <= (bit_cnt == 4'h9) ? 4'h1 : bit_cnt + 4'h1;
                if (bit_cnt == 4'h9)
                    first_byte <= 1'b0;
            end
        end
    end
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    sequence start_s; scl && $past(scl) && $fell(sda); endsequence
    sequence stop_s; scl && $past(scl) && $rose(sda); endsequence
    dev_chg_low_a: assert property ($changed(s_sda_oe) |-> !scl && $past(!scl, 2))
        else $error("device data moved while clock high");
    scl_high_len_a: assert property ($rose(scl) |-> scl [*8])
        else $error("clock high phase too short");
    scl_low_len_a: assert property ($fell(scl) |-> !scl [*8])
        else $error("clock low phase too short");
    start_host_a: assert property (start_s |-> m_sda_oe && !s_sda_oe)
        else $error("start not made by host");
    stop_host_a: assert property (stop_s |-> $past(m_sda_oe) && !s_sda_oe)
        else $error("stop not made by host");
    stop_idle_a: assert property (stop_s |=> !s_sda_oe [*8])
        else $error("device drove after stop");
    addr_ack_a: assert property (first_byte && scl && $past(scl) && s_sda_oe |-> bit_cnt == 4'h9)
        else $error("device drove address bits");
    ack_free_a: assert property (first_byte && bit_cnt == 4'h9 && scl && $past(scl) |-> !m_sda_oe)
        else $error("host held line in address ack");
endmodule // dac_link_asserts

// [bench/tb.sv]
// Self-checking bench for the two-wire converter link.
`timescale 1ns/1ps
module tb
    import dac_link_pkg::*;
;
    // ********
    // Bench
    // ********
    logic             pclk = 1'b0;
    logic             presetn = 1'b0;
    logic             psel = 1'b0;
    logic             penable = 1'b0;
    logic             pwrite = 1'b0;
    logic [11:0]      paddr = 12'h000;
    logic [31:0]      pwdata = 32'h0;
    logic             pin_sel = 1'b0;
    wire logic [31:0] prdata;
    wire logic        pready;
    wire logic        pslverr;
    wire logic [15:0] dac_code;
    wire logic        conv_start;
    wire logic [1:0]  update_mode;
    wire logic        broadcast_sel;
    wire logic        powerdown_flag_bit;
    wire logic        powerdown_mode_bit_a;
    wire logic        powerdown_mode_bit_b;
    wire logic        powerdown_mode_bit_c;
    int               err_total = 0;
    int               check_count = 0;
    int               conv_n = 0;
    int               conv_exp = 0;
    integer           seed = 32'he753c63e;
    logic [31:0]      rd;
    logic [31:0]      r;
    logic             perr;
    logic [15:0]      code_m;
    logic [7:0]       ctrl_m;
    dac_link_if link_bus ();
    always #2.5 pclk = ~pclk;
    dac_link_host u_dac_link_host (.pclk, .presetn, .link(link_bus), .psel, .penable, .pwrite, .paddr, .pwdata,
        .prdata, .pready, .pslverr);
    dac_link_device u_dac_link_device (.pclk, .presetn, .link(link_bus), .address_select_pin(pin_sel), .dac_code,
        .conv_start, .update_mode, .broadcast_sel, .powerdown_flag_bit, .powerdown_mode_bit_a,
        .powerdown_mode_bit_b, .powerdown_mode_bit_c);
    dac_link_asserts u_dac_link_asserts (.pclk, .presetn, .m_sda_oe(link_bus.m_sda_oe),
        .s_sda_oe(link_bus.s_sda_oe), .scl(link_bus.scl), .sda(link_bus.sda));
    always @(posedge pclk) if (conv_start === 1'b1) conv_n <= conv_n + 1;
    task chk(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            err_total++;
            $display("mismatch t=%0t got %h exp %h", $time, got, exp);
        end
    endtask
    function automatic logic [2:0] exp_fields(input logic [7:0] c);
        return {c[CTRL_UPD_HI:CTRL_UPD_LO], c[CTRL_BCAST]};
    endfunction
    function automatic logic [3:0] exp_pd(input logic [15:0] d, input logic [7:0] c);
        return {d[PD_MODE_HI:PD_MODE_LO], c[CTRL_PD]};
    endfunction
    task tally_and_finish;
        $display("errors %0d checks %0d", err_total, check_count);
        if (err_total == 0 && check_count > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    task apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) @(posedge pclk);
        rd = prdata;
        perr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask
    task run(input logic [4:0] cmd);
        apb(1'b1, CMD_OFS, {27'h0, cmd});
        do apb(1'b0, STATUS_OFS, 32'h0); while (rd[ST_BUSY] !== 1'b0);
        repeat (8) @(posedge pclk);
    endtask
    task wr_code(input logic sel, input logic hold, input logic [7:0] c, input logic [15:0] d);
        apb(1'b1, CTRL_OFS, {24'h0, c});
        apb(1'b1, DATA_OFS, {16'h0, d});
        run({1'b0, hold, sel, 1'b0, 1'b1});
    endtask
    initial begin
        repeat (100000) @(posedge pclk);
        err_total++;
        tally_and_finish();
    end
    initial begin
        repeat (12) @(posedge pclk);
        presetn <= 1'b1;
        repeat (3) @(posedge pclk);
        chk(dac_code, 32'h0);
        apb(1'b0, CTRL_OFS, 32'h0);
        chk(rd, {24'h0, CTRL_RST});
        apb(1'b0, DATA_OFS, 32'h0);
        chk(rd, {16'h0, DATA_RST});
        apb(1'b0, 12'h010, 32'h0);
        chk({31'h0, perr}, 32'h1);
        apb(1'b0, CMD_OFS, 32'h0);
        chk(rd, 32'h0);
        for (int i = 0; i < 3; i++) begin
            r = $random(seed);
            pin_sel <= r[8];
            ctrl_m = {2'b00, r[1:0], 1'b0, r[2], 2'b00};
            code_m = (i == 0) ? 16'hffff : r[31:16];
            wr_code(r[8], i[0], ctrl_m, code_m);
            conv_exp++;
            chk(rd[ST_NACK], 32'h0);
            chk(dac_code, code_m);
            chk({update_mode, broadcast_sel}, exp_fields(ctrl_m));
            chk(conv_n, conv_exp);
            if (i == 1) begin
                code_m = r[15:0];
                apb(1'b1, DATA_OFS, {16'h0, code_m});
                run({2'b11, r[8], 2'b01});
                conv_exp++;
                chk(dac_code, code_m);
                chk(conv_n, conv_exp);
            end
        end
        wr_code(!pin_sel, 1'b0, 8'h00, 16'h1234);
        chk(rd[ST_NACK], 32'h1);
        chk(dac_code, code_m);
        chk(conv_n, conv_exp);
        ctrl_m = 8'h01;
        wr_code(pin_sel, 1'b0, ctrl_m, 16'ha000);
        conv_exp++;
        chk({powerdown_mode_bit_a, powerdown_mode_bit_b, powerdown_mode_bit_c, powerdown_flag_bit},
            exp_pd(16'ha000, ctrl_m));
        chk(dac_code, code_m);
        chk(conv_n, conv_exp);
        run({2'b00, pin_sel, 2'b11});
        chk(rd[15:8], ctrl_m);
        chk(rd[ST_NACK], 32'h0);
        apb(1'b0, DATA_OFS, 32'h0);
        chk(rd[15:0], code_m);
        tally_and_finish();
    end
endmodule // tb
